// *** rtl/sxe_pkg.sv ***
`default_nettype none
package sxe_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CMD       = 8'h00;
  localparam logic [7:0] OFS_ACC       = 8'h04;
  localparam logic [7:0] OFS_FLAGS     = 8'h08;
  localparam logic [7:0] OFS_TBL_LO    = 8'h0c;
  localparam logic [7:0] OFS_TBL_HI    = 8'h10;
  localparam logic [7:0] OFS_TBL_LATCH = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;
  localparam logic [7:0] OFS_DM_ADDR   = 8'h1c;
  localparam logic [7:0] OFS_DM_DATA   = 8'h20;
  localparam logic [7:0] OFS_PM_ADDR   = 8'h24;
  localparam logic [7:0] OFS_PM_DATA   = 8'h28;
  localparam logic [7:0] OFS_PAGE      = 8'h2c;
  // field positions, widths and fixed values
  localparam int unsigned FLAG_Z       = 0;
  localparam int unsigned ST_BUSY_BIT  = 0;
  localparam int unsigned ST_SKIP_BIT  = 1;
  localparam int unsigned ST_CYC_LSB   = 4;
  localparam int unsigned PAGE_W       = 8;
  localparam logic [1:0]  SKIP_CYCLES  = 2'h2;
  localparam logic [7:0]  LAST_PAGE    = 8'hff;

  typedef enum logic [3:0] {
    OP_NONE         = 4'h0,
    OP_SKIP_ZERO    = 4'h1,
    OP_MOVE_SKIP    = 4'h2,
    OP_SKIP_BIT     = 4'h3,
    OP_TRD_CUR      = 4'h4,
    OP_TRD_LAST     = 4'h5,
    OP_TRD_INC      = 4'h6,
    OP_TRD_INC_LAST = 4'h7,
    OP_XOR_ACC      = 4'h8,
    OP_XOR_MEM      = 4'h9,
    OP_SWAP_ACC     = 4'ha
  } sxe_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_DUMMY = 2'b11
  } sxe_state_t;

  typedef struct packed {
    sxe_op_t    op;
    logic [2:0] bit_sel;
    logic [7:0] addr;
  } sxe_cmd_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sxe_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } sxe_apb_rsp_t;

  typedef struct packed {
    sxe_state_t   state;
    sxe_cmd_t     cmd;
    logic [7:0]   acc;
    logic [5:0]   flags;
    logic [7:0]   table_pointer_low;
    logic [7:0]   table_pointer_high;
    logic [7:0]   table_high_latch;
    logic [7:0]   page;
    logic         skip;
    logic [1:0]   cycles;
    logic [7:0]   dm_addr;
    logic [15:0]  pm_addr;
    sxe_apb_rsp_t rsp;
  } sxe_regs_t;

  localparam sxe_regs_t REGS_RST = '0;
endpackage
`default_nettype wire

// *** rtl/sxe_exec.sv ***
`default_nettype none
// Summary of operation
// RULE1 - the byte skip skips the next instruction when the memory byte is 0.
// RULE2 - move-and-skip copies the byte to acc and skips when it is zero.
// RULE3 - the bit skip skips the next instruction when the chosen bit is 0.
// RULE4 - every conditional skip takes two cycles, the second a dummy one.
// RULE5 - current-page table read stores the low byte to memory, high to latch.
// RULE6 - last-page table read does the same from the last program page.
// RULE7 - pre-increment read bumps the pointer low byte, then reads high:low.
// RULE8 - last-page pre-increment read bumps the pointer, then reads last page.
// RULE9 - xor to acc writes acc xor byte into acc and updates only zero flag.
// RULE10 - xor to memory writes acc xor byte back and updates only zero flag.
// RULE11 - skips, table reads and nibble swap leave every status flag alone.
// RULE12 - nibble swap puts the swapped byte in acc, memory left unchanged.
// RULE13 - the incremented pointer low byte stays, wrapping within 8 bits.
module sxe_exec
  import sxe_pkg::*;
#(
  parameter int unsigned PMEM_AW = 12
) (
  input  wire logic         sys_clk,  // core clock
  input  wire logic         rst,      // sync reset, active high
  input  wire sxe_apb_req_t apb_req,  // apb request from master
  output var  sxe_apb_rsp_t apb_rsp   // apb answer, registered
);

  if (PMEM_AW < 9 || PMEM_AW > 16) begin : g_bad_aw
    $error("sxe_exec: PMEM_AW must be 9 to 16");
  end

  localparam int unsigned HI_W = PMEM_AW - PAGE_W;

  sxe_regs_t s_q;
  sxe_regs_t s_d;

  logic [7:0]         dmem [256];
  logic [15:0]        pmem [2**PMEM_AW];
  logic               dm_we;
  logic [7:0]         dm_wa;
  logic [7:0]         dm_wd;
  logic               pm_we;
  logic [7:0]         dm_rd;
  logic [15:0]        pm_rd;
  logic [PMEM_AW-1:0] tab_addr;
  logic [7:0]         table_pointer_low_eff;
  logic [7:0]         hi_sel;
  logic [7:0]         xor_res;
  logic [7:0]         swap_res;
  logic [7:0]         pm_hi;
  logic               op_zero;
  logic               bit_zero;
  logic               is_skip;
  logic               is_inc;
  logic               ex;

  assign ex       = (s_q.state == ST_EXEC);
  assign dm_rd    = dmem[s_q.cmd.addr];
  assign op_zero  = (dm_rd == 8'h00);
  assign bit_zero = ~dm_rd[s_q.cmd.bit_sel];
  assign xor_res  = s_q.acc ^ dm_rd;
  assign swap_res = {dm_rd[3:0], dm_rd[7:4]};                 // [RULE12]
  assign is_skip  = (s_q.cmd.op == OP_SKIP_ZERO) ||
                    (s_q.cmd.op == OP_MOVE_SKIP) ||
                    (s_q.cmd.op == OP_SKIP_BIT);
  assign is_inc   = (s_q.cmd.op == OP_TRD_INC) ||
                    (s_q.cmd.op == OP_TRD_INC_LAST);
  // pointer bumped before the fetch, same cycle   [RULE7] [RULE8]
  assign table_pointer_low_eff = is_inc ? 8'(s_q.table_pointer_low + 8'h01) : s_q.table_pointer_low;

  always_comb begin
    case (s_q.cmd.op)
      OP_TRD_LAST,
      OP_TRD_INC_LAST: hi_sel = LAST_PAGE;                    // [RULE6] [RULE8]
      OP_TRD_INC:      hi_sel = s_q.table_pointer_high;                     // [RULE7]
      default:         hi_sel = s_q.page;                     // [RULE5]
    endcase
  end

  assign tab_addr = {hi_sel[HI_W-1:0], table_pointer_low_eff};
  assign pm_rd    = pmem[tab_addr];
  assign pm_hi    = pm_rd[15:8];

  always_comb begin
    logic        setup;
    logic        done;
    logic        err;
    logic [31:0] rdata;
    logic [7:0]  res;
    s_d   = s_q;
    dm_we = 1'b0;
    dm_wa = s_q.cmd.addr;
    dm_wd = 8'h00;
    pm_we = 1'b0;
    setup = apb_req.psel & ~apb_req.penable;
    done  = apb_req.psel & apb_req.penable & s_q.rsp.pready;
    err   = 1'b0;
    rdata = 32'h0000_0000;
    res   = 8'h00;
    s_d.rsp.pready = 1'b0;

    // answer decided at setup; writes refused while an op is running
    case (apb_req.paddr)
      OFS_CMD:       rdata = {17'h0_0000, s_q.cmd};
      OFS_ACC:       rdata = {24'h00_0000, s_q.acc};
      OFS_FLAGS:     rdata = {26'h000_0000, s_q.flags};
      OFS_TBL_LO:    rdata = {24'h00_0000, s_q.table_pointer_low};
      OFS_TBL_HI:    rdata = {24'h00_0000, s_q.table_pointer_high};
      OFS_TBL_LATCH: begin
        rdata = {24'h00_0000, s_q.table_high_latch};
        err   = apb_req.pwrite;
      end
      OFS_STATUS: begin
        rdata[ST_BUSY_BIT] = (s_q.state != ST_IDLE);
        rdata[ST_SKIP_BIT] = s_q.skip;
        rdata[ST_CYC_LSB +: 2] = s_q.cycles;
        err = apb_req.pwrite;
      end
      OFS_DM_ADDR:   rdata = {24'h00_0000, s_q.dm_addr};
      OFS_DM_DATA:   rdata = {24'h00_0000, dmem[s_q.dm_addr]};
      OFS_PM_ADDR:   rdata = {16'h0000, s_q.pm_addr};
      OFS_PM_DATA:   rdata = {16'h0000, pmem[s_q.pm_addr[PMEM_AW-1:0]]};
      OFS_PAGE:      rdata = {24'h00_0000, s_q.page};
      default:       err = 1'b1;
    endcase
    if (apb_req.pwrite && s_q.state != ST_IDLE) begin
      err = 1'b1;
    end
    if (apb_req.pwrite && apb_req.paddr == OFS_CMD &&
        (apb_req.pwdata[14:11] == OP_NONE ||
         apb_req.pwdata[14:11] > OP_SWAP_ACC)) begin
      err = 1'b1;
    end
    if (setup) begin
      s_d.rsp.pready  = 1'b1;
      s_d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
      s_d.rsp.pslverr = err;
    end

    if (done && apb_req.pwrite && !s_q.rsp.pslverr) begin
      case (apb_req.paddr)
        OFS_CMD: begin
          s_d.cmd    = sxe_cmd_t'(apb_req.pwdata[14:0]);
          s_d.state  = ST_EXEC;
          s_d.skip   = 1'b0;
          s_d.cycles = 2'h0;
        end
        OFS_ACC:     s_d.acc     = apb_req.pwdata[7:0];
        OFS_FLAGS:   s_d.flags   = apb_req.pwdata[5:0];
        OFS_TBL_LO:  s_d.table_pointer_low    = apb_req.pwdata[7:0];
        OFS_TBL_HI:  s_d.table_pointer_high    = apb_req.pwdata[7:0];
        OFS_DM_ADDR: s_d.dm_addr = apb_req.pwdata[7:0];
        OFS_DM_DATA: begin
          dm_we = 1'b1;
          dm_wa = s_q.dm_addr;
          dm_wd = apb_req.pwdata[7:0];
        end
        OFS_PM_ADDR: s_d.pm_addr = apb_req.pwdata[15:0];
        OFS_PM_DATA: pm_we = 1'b1;
        OFS_PAGE:    s_d.page    = apb_req.pwdata[7:0];
        default: ;
      endcase
    end

    // flags only touched by the xor ops   [RULE11]
    case (s_q.state)
      ST_EXEC: begin
        s_d.cycles = 2'h1;
        s_d.state  = is_skip ? ST_DUMMY : ST_IDLE;            // [RULE4]
        case (s_q.cmd.op)
          OP_SKIP_ZERO: s_d.skip = op_zero;                   // [RULE1]
          OP_MOVE_SKIP: begin
            s_d.acc  = dm_rd;                                 // [RULE2]
            s_d.skip = op_zero;                               // [RULE2]
          end
          OP_SKIP_BIT:  s_d.skip = bit_zero;                  // [RULE3]
          OP_TRD_CUR, OP_TRD_LAST, OP_TRD_INC, OP_TRD_INC_LAST: begin
            s_d.table_pointer_low = table_pointer_low_eff;                              // [RULE13]
            s_d.table_high_latch = pm_hi;                       // [RULE5] [RULE6]
            dm_we    = 1'b1;                        // [RULE7] [RULE8]
            dm_wd    = pm_rd[7:0];
          end
          OP_XOR_ACC: begin
            s_d.acc = xor_res;                                // [RULE9]
            s_d.flags[FLAG_Z] = (xor_res == 8'h00);           // [RULE9]
          end
          OP_XOR_MEM: begin
            res   = xor_res;
            dm_we = 1'b1;                                     // [RULE10]
            dm_wd = res;
            s_d.flags[FLAG_Z] = (res == 8'h00);               // [RULE10]
          end
          OP_SWAP_ACC: s_d.acc = swap_res;                    // [RULE12]
          default: ;
        endcase
      end
      // dummy slot stands in for the fetch of the next instruction
      ST_DUMMY: begin
        s_d.cycles = SKIP_CYCLES;                             // [RULE4]
        s_d.state  = ST_IDLE;
      end
      ST_IDLE: ;
      default: s_d.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= REGS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // memories hold no reset; software loads them before use
  always_ff @(posedge sys_clk) begin
    if (dm_we) begin
      dmem[dm_wa] <= dm_wd;
    end
    if (pm_we) begin
      pmem[s_q.pm_addr[PMEM_AW-1:0]] <= apb_req.pwdata[15:0];
    end
  end

  assign apb_rsp = s_q.rsp;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_SKIP_BYTE: assert property ( // [RULE1]
    ex && s_q.cmd.op == OP_SKIP_ZERO |=> s_q.skip == $past(op_zero))
    else $error("byte skip decision wrong");

  AST_MOVE_SKIP: assert property ( // [RULE2]
    ex && s_q.cmd.op == OP_MOVE_SKIP
    |=> s_q.acc == $past(dm_rd) && s_q.skip == (s_q.acc == 8'h00))
    else $error("move and skip wrong");

  AST_SKIP_BIT: assert property ( // [RULE3]
    ex && s_q.cmd.op == OP_SKIP_BIT |=> s_q.skip == $past(bit_zero))
    else $error("bit skip decision wrong");

  AST_SKIP_TWO: assert property ( // [RULE4]
    ex && is_skip |=> s_q.state == ST_DUMMY
    ##1 s_q.state == ST_IDLE && s_q.cycles == SKIP_CYCLES)
    else $error("skip did not take two cycles");

  AST_TRD_CUR: assert property ( // [RULE5]
    ex && s_q.cmd.op == OP_TRD_CUR
    |-> tab_addr == {s_q.page[HI_W-1:0], s_q.table_pointer_low} && dm_we
    ##1 s_q.table_high_latch == $past(pm_hi) && $stable(s_q.table_pointer_low))
    else $error("current page table read wrong");

  AST_TRD_LAST: assert property ( // [RULE6]
    ex && (s_q.cmd.op == OP_TRD_LAST || s_q.cmd.op == OP_TRD_INC_LAST)
    |-> &tab_addr[PMEM_AW-1:PAGE_W] && dm_wd == pm_rd[7:0])
    else $error("last page table read wrong");

  AST_TRD_INC: assert property ( // [RULE7]
    ex && s_q.cmd.op == OP_TRD_INC
    |-> tab_addr == {s_q.table_pointer_high[HI_W-1:0], 8'(s_q.table_pointer_low + 8'h01)})
    else $error("pre-increment table address wrong");

  AST_TRD_INC_LAST: assert property ( // [RULE8]
    ex && s_q.cmd.op == OP_TRD_INC_LAST
    |-> tab_addr[7:0] == 8'(s_q.table_pointer_low + 8'h01) ##1 s_q.table_high_latch == $past(pm_hi))
    else $error("last page pre-increment read wrong");

  AST_TABLE_POINTER_LOW_KEEP: assert property ( // [RULE13]
    ex && is_inc |=> s_q.table_pointer_low == 8'($past(s_q.table_pointer_low) + 8'h01)
    ##1 s_q.state == ST_IDLE)
    else $error("pointer increment lost");

  AST_XOR_ACC: assert property ( // [RULE9]
    ex && s_q.cmd.op == OP_XOR_ACC
    |=> s_q.acc == $past(xor_res) &&
        s_q.flags[FLAG_Z] == (s_q.acc == 8'h00) &&
        s_q.flags[5:1] == $past(s_q.flags[5:1]))
    else $error("xor to acc wrong");

  AST_XOR_MEM: assert property ( // [RULE10]
    ex && s_q.cmd.op == OP_XOR_MEM
    |-> dm_we && dm_wd == (s_q.acc ^ dm_rd)
    ##1 $stable(s_q.acc) && s_q.flags[5:1] == $past(s_q.flags[5:1]))
    else $error("xor to memory wrong");

  AST_FLAGS_KEEP: assert property ( // [RULE11]
    ex && s_q.cmd.op != OP_XOR_ACC && s_q.cmd.op != OP_XOR_MEM
    |=> $stable(s_q.flags))
    else $error("flags changed by flag-neutral op");

  AST_SWAP: assert property ( // [RULE12]
    ex && s_q.cmd.op == OP_SWAP_ACC
    |-> !dm_we ##1 s_q.acc == {$past(dm_rd[3:0]), $past(dm_rd[7:4])})
    else $error("nibble swap wrong");

  COV_SKIP_TAKEN: cover property (
    ex && is_skip ##1 s_q.skip ##1 s_q.state == ST_IDLE);
  COV_TRD_WRAP: cover property (ex && is_inc && s_q.table_pointer_low == 8'hff);
  COV_XOR_ZERO: cover property (
    ex && s_q.cmd.op == OP_XOR_MEM && xor_res == 8'h00);
  COV_APB_ERR: cover property (s_q.rsp.pready && s_q.rsp.pslverr);

endmodule
`default_nettype wire

// *** tb/sxe_apb_master.sv ***
`default_nettype none
module sxe_apb_master
  import sxe_pkg::*;
(
  input  wire logic         sys_clk, // core clock
  input  wire sxe_apb_rsp_t rsp,     // answer from the slave
  output var  sxe_apb_req_t req      // request to the slave
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req = '0;

  // a dead slave returns unknown data and error, so the bench sees it
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic er);
    int n;
    n = 0;
    rd = 'x;
    er = 1'bx;
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    // held until the edge that samples pready high
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready === 1'b1) begin
      rd = rsp.prdata;
      er = rsp.pslverr;
    end
    req <= '0;
  endtask
endmodule
`default_nettype wire

// *** tb/sxe_exec_tb_top.sv ***
`default_nettype none
module sxe_exec_tb_top
  import sxe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         sys_clk = 1'b0;
  logic         rst     = 1'b1;
  sxe_apb_req_t apb_req;
  sxe_apb_rsp_t apb_rsp;
  int           errors      = 0;
  int           check_count = 0;
  logic [31:0]  v;
  logic         e;

  always #5 sys_clk = ~sys_clk;

  sxe_exec #(.PMEM_AW(12)) DUT (
    .sys_clk(sys_clk),
    .rst    (rst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp)
  );

  sxe_apb_master m (
    .sys_clk(sys_clk),
    .rsp    (apb_rsp),
    .req    (apb_req)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m.xfer(1'b1, a, d, v, e);
    chk({31'h0, e}, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    m.xfer(1'b0, a, 32'h0, v, e);
    chk({31'h0, e}, 32'h0);
    chk(v, x);
  endtask

  task automatic dm(input logic [7:0] a, input logic [7:0] d);
    wr(OFS_DM_ADDR, {24'h0, a});
    wr(OFS_DM_DATA, {24'h0, d});
  endtask

  task automatic dmchk(input logic [7:0] a, input logic [7:0] x);
    wr(OFS_DM_ADDR, {24'h0, a});
    rd(OFS_DM_DATA, {24'h0, x});
  endtask

  task automatic st(input logic s, input logic [1:0] c);
    rd(OFS_STATUS, {26'h0, c, 2'b00, s, 1'b0});
  endtask

  // op sits in both fields, so the low address nibble equals the op
  task automatic exec(input sxe_op_t op, input logic [2:0] b,
                      input logic [3:0] hi);
    int n;
    n = 0;
    wr(OFS_CMD, {17'h0, op, b, hi, op});
    v = 32'h1;
    while (v[ST_BUSY_BIT] !== 1'b0 && n < 8) begin
      m.xfer(1'b0, OFS_STATUS, 32'h0, v, e);
      n++;
    end
    chk({31'h0, v[ST_BUSY_BIT]}, 32'h0);
  endtask

  task automatic test_reset;
    logic [7:0] ofs [7] = '{OFS_ACC, OFS_FLAGS, OFS_TBL_LO, OFS_TBL_HI,
                            OFS_TBL_LATCH, OFS_STATUS, OFS_PAGE};
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    m.xfer(1'b0, 8'h30, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    chk(v, 32'h0);
    m.xfer(1'b1, OFS_TBL_LATCH, 32'h5a, v, e);
    chk({31'h0, e}, 32'h1);
    m.xfer(1'b1, OFS_CMD, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    $display("test_reset done");
  endtask

  task automatic test_skip;
    logic [7:0] pat = 8'ha5;
    wr(OFS_FLAGS, 32'h15);
    dm(8'h31, 8'h00);
    exec(OP_SKIP_ZERO, 3'h0, 4'h3);
    st(1'b1, SKIP_CYCLES);
    dm(8'h31, 8'h01);
    exec(OP_SKIP_ZERO, 3'h0, 4'h3);
    st(1'b0, SKIP_CYCLES);
    wr(OFS_ACC, 32'h77);
    dm(8'h32, 8'h00);
    exec(OP_MOVE_SKIP, 3'h0, 4'h3);
    st(1'b1, SKIP_CYCLES);
    rd(OFS_ACC, 32'h0);
    dm(8'h32, 8'h80);
    exec(OP_MOVE_SKIP, 3'h0, 4'h3);
    st(1'b0, SKIP_CYCLES);
    rd(OFS_ACC, 32'h80);
    dm(8'h33, pat);
    for (int i = 0; i < 8; i++) begin
      exec(OP_SKIP_BIT, i[2:0], 4'h3);
      st(~pat[i], SKIP_CYCLES);
    end
    rd(OFS_FLAGS, 32'h15);
    $display("test_skip done");
  endtask

  task automatic test_table;
    sxe_op_t     op [5] = '{OP_TRD_CUR, OP_TRD_LAST, OP_TRD_INC,
                            OP_TRD_INC_LAST, OP_TRD_INC_LAST};
    logic [7:0]  p0 [5] = '{8'h10, 8'h20, 8'hff, 8'h7f, 8'hff};
    logic [11:0] pa [5] = '{12'h310, 12'hf20, 12'h200, 12'hf80, 12'hf00};
    logic [15:0] w;
    wr(OFS_PAGE, 32'h3);
    wr(OFS_TBL_HI, 32'h2);
    wr(OFS_FLAGS, 32'h2a);
    for (int i = 0; i < 5; i++) begin
      w = {pa[i][11:4] ^ 8'ha5, pa[i][7:0] ^ 8'h3c};
      wr(OFS_PM_ADDR, {20'h0, pa[i]});
      wr(OFS_PM_DATA, {16'h0, w});
      wr(OFS_TBL_LO, {24'h0, p0[i]});
      dm({4'h5, op[i]}, ~w[7:0]);
      exec(op[i], 3'h0, 4'h5);
      dmchk({4'h5, op[i]}, w[7:0]);
      rd(OFS_TBL_LATCH, {24'h0, w[15:8]});
      rd(OFS_TBL_LO, {24'h0, pa[i][7:0]});
    end
    rd(OFS_TBL_HI, 32'h2);
    rd(OFS_FLAGS, 32'h2a);
    $display("test_table done");
  endtask

  task automatic test_xor_swap;
    wr(OFS_FLAGS, 32'h2a);
    wr(OFS_ACC, 32'h5a);
    dm(8'h78, 8'h5a);
    exec(OP_XOR_ACC, 3'h0, 4'h7);
    rd(OFS_ACC, 32'h0);
    rd(OFS_FLAGS, 32'h2b);
    dmchk(8'h78, 8'h5a);
    wr(OFS_ACC, 32'h0f);
    dm(8'h69, 8'hf0);
    exec(OP_XOR_MEM, 3'h0, 4'h6);
    dmchk(8'h69, 8'hff);
    rd(OFS_ACC, 32'h0f);
    rd(OFS_FLAGS, 32'h2a);
    wr(OFS_FLAGS, 32'h15);
    dm(8'h4a, 8'h3c);
    exec(OP_SWAP_ACC, 3'h0, 4'h4);
    rd(OFS_ACC, 32'hc3);
    dmchk(8'h4a, 8'h3c);
    rd(OFS_FLAGS, 32'h15);
    $display("test_xor_swap done");
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // whole run needs several hundred cycles
  initial begin
    #50us;
    errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_skip();
    test_table();
    test_xor_swap();
    summarize();
  end
endmodule
`default_nettype wire
